//--- verilog/t1ag_top.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module t1ag_top
  import t1ag_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  input  wire logic        TX_BIT_EN,
  input  wire logic        TX_DATA_IN,
  input  wire logic        TX_FBIT,
  input  wire logic        TX_DL_BIT,
  input  wire logic        TX_FRAME_START,
  input  wire logic [4:0]  TX_FRAME_NUM,
  input  wire logic [4:0]  TX_SLOT,
  input  wire logic [2:0]  TX_BIT_POS,
  input  wire logic        RX_LOF,
  output logic             TX_DATA_OUT,
  output logic             TX_DATA_VALID,
  output logic             RED_ALARM,
  output logic             RX_FRAME_LOSS_IRQ
);

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_ff,   nxt_ctrl;
  t1ag_fmt_e   mode_ff,   nxt_mode;
  logic        wpend_ff,  nxt_wpend;
  logic [11:0] waddr_ff,  nxt_waddr;
  logic [31:0] rdata_ff,  nxt_rdata;
  logic [7:0]  pcnt_ff,   nxt_pcnt;
  logic        lof_ff,    nxt_lof;

  typedef enum logic {T1AG_IDLE = 1'b0, T1AG_SEND = 1'b1} t1ag_yst_e;
  t1ag_yst_e   yst_ff,    nxt_yst;

  logic        take;

  function automatic logic [31:0] reg_read(input logic [11:0] a, input logic [7:0] c,
                                           input t1ag_fmt_e m, input logic [10:0] st);
    logic [31:0] v;
    v = 32'h0;
    if (a == T1AG_CTRL_OFS) v = {24'h0, c};
    else if (a == T1AG_MODE_OFS) v = {30'h0, m};
    else if (a == T1AG_STAT_OFS) v = {21'h0, st};
    return v;
  endfunction

  assign take = HSEL & HTRANS[1] & HREADY;

  always_comb begin
    logic [7:0] cur_ctrl;
    cur_ctrl  = ctrl_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_mode  = mode_ff;
    nxt_wpend = take & HWRITE;
    nxt_waddr = take ? {HADDR[11:2], 2'b00} : waddr_ff;
    nxt_rdata = rdata_ff;
    if (wpend_ff && waddr_ff == T1AG_CTRL_OFS) begin
      nxt_ctrl = HWDATA[7:0];
    end
    if (wpend_ff && waddr_ff == T1AG_MODE_OFS) begin
      nxt_mode = t1ag_fmt_e'(HWDATA[1:0]);
    end
    // forward a write still in its data phase so a back-to-back read sees it
    cur_ctrl = nxt_ctrl;
    if (take && !HWRITE) begin
      nxt_rdata = reg_read({HADDR[11:2], 2'b00}, cur_ctrl, nxt_mode,
                           {pcnt_ff, yst_ff == T1AG_SEND, RED_ALARM, lof_ff});
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_ff   <= T1AG_CTRL_RST;
      mode_ff   <= t1ag_fmt_e'(T1AG_MODE_RST);
      wpend_ff  <= 1'b0;
      waddr_ff  <= 12'h000;
      rdata_ff  <= 32'h0;
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      mode_ff   <= nxt_mode;
      wpend_ff  <= nxt_wpend;
      waddr_ff  <= nxt_waddr;
      rdata_ff  <= nxt_rdata;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end
  assign HRDATA = rdata_ff;

  // ---------------------------------------------------------------
  // frame loss, red alarm, interrupt
  // ---------------------------------------------------------------
  logic red_nxt, irq_nxt;
  always_comb begin
    nxt_lof = RX_LOF;
    red_nxt = ctrl_ff[T1AG_LOF_EN] & RX_LOF;
    irq_nxt = RX_LOF & ~lof_ff;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      lof_ff            <= 1'b0;
      RED_ALARM         <= 1'b0;
      RX_FRAME_LOSS_IRQ <= 1'b0;
    end else begin
      lof_ff            <= nxt_lof;
      RED_ALARM         <= red_nxt;
      RX_FRAME_LOSS_IRQ <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // esf data-link yellow sequencer
  // ---------------------------------------------------------------
  logic       b0q_ff, nxt_b0q;
  logic [3:0] bcnt_ff, nxt_bcnt;
  logic       esf, timed, b0_rise, hold, pat_end;
  always_comb begin
    esf     = (mode_ff == T1AG_ESF);
    timed   = ctrl_ff[T1AG_YL_B0];
    b0_rise = timed & ~b0q_ff;
    // send while held high or in red alarm
    hold    = (timed & ctrl_ff[T1AG_YL_B1]) | (timed & ~ctrl_ff[T1AG_YL_B1]) |
              (~timed & ctrl_ff[T1AG_YL_B1]) | RED_ALARM;
    pat_end = TX_BIT_EN & TX_DL_BIT & (bcnt_ff == T1AG_PAT_LAST);
    nxt_b0q  = timed;
    nxt_yst  = yst_ff;
    nxt_pcnt = pcnt_ff;
    nxt_bcnt = bcnt_ff;
    if (!esf) begin
      nxt_yst  = T1AG_IDLE;
      nxt_pcnt = 8'h00;
      nxt_bcnt = 4'h0;
    end else if (yst_ff == T1AG_IDLE) begin
      nxt_bcnt = 4'h0;
      if (b0_rise || hold) begin
        nxt_yst = T1AG_SEND;
      end
      if (b0_rise) begin
        nxt_pcnt = T1AG_PAT_RUN;
      end
    end else begin
      if (TX_BIT_EN && TX_DL_BIT) begin
        nxt_bcnt = bcnt_ff + 4'h1;
      end
      if (pat_end) begin
        nxt_pcnt = (pcnt_ff > 8'h01) ? pcnt_ff - 8'h01 : 8'h00;
        // stop only on a whole pattern once nothing holds it
        if (pcnt_ff <= 8'h01 && !hold) begin
          nxt_yst = T1AG_IDLE;
        end
      end
      if (b0_rise) begin
        nxt_pcnt = T1AG_PAT_RUN;
        nxt_yst  = T1AG_SEND;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      b0q_ff  <= 1'b0;
      yst_ff  <= T1AG_IDLE;
      pcnt_ff <= 8'h00;
      bcnt_ff <= 4'h0;
    end else begin
      b0q_ff  <= nxt_b0q;
      yst_ff  <= nxt_yst;
      pcnt_ff <= nxt_pcnt;
      bcnt_ff <= nxt_bcnt;
    end
  end

  // ---------------------------------------------------------------
  // transmit bit path
  // ---------------------------------------------------------------
  logic [1:0] ais_ff, nxt_ais, ysel_ff, nxt_ysel;
  logic [1:0] ycode;
  logic       out_nxt;
  always_comb begin
    nxt_ais  = ais_ff;
    nxt_ysel = ysel_ff;
    if (TX_BIT_EN && TX_FRAME_START) begin
      nxt_ais  = ctrl_ff[T1AG_AIS_LO +: 2];
      nxt_ysel = ctrl_ff[T1AG_YL_B0 +: 2];
    end
    // the frame-start bit already uses the new selects, so no frame is split
    // red alarm forces the bit-2 form when software selected none
    ycode   = (nxt_ysel == T1AG_YL_OFF && RED_ALARM) ? T1AG_YL_BIT2 : nxt_ysel;
    out_nxt = TX_DATA_IN;
    if (ycode != T1AG_YL_OFF) begin
      unique case (mode_ff)
        T1AG_SF: begin
          if (ycode == T1AG_YL_FR12) begin
            if (TX_FBIT && TX_FRAME_NUM == T1AG_FRAME_12) out_nxt = 1'b1;
          end else if (!TX_FBIT && TX_BIT_POS == T1AG_SECOND_MSB) begin
            out_nxt = 1'b0;
          end
        end
        T1AG_NFM: if (!TX_FBIT && TX_BIT_POS == T1AG_SECOND_MSB) out_nxt = 1'b0;
        T1AG_DMF: if (!TX_FBIT && TX_SLOT == T1AG_DM_SLOT && TX_BIT_POS == T1AG_DM_YBIT) out_nxt = 1'b0;
        T1AG_ESF: out_nxt = TX_DATA_IN;
      endcase
    end
    if (esf && yst_ff == T1AG_SEND && TX_DL_BIT) begin
      out_nxt = (bcnt_ff < T1AG_PAT_HALF);
    end
    // ais overrides yellow, framed keeps fbits untouched
    if (nxt_ais == T1AG_AIS_UNFR) begin
      out_nxt = 1'b1;
    end else if (nxt_ais == T1AG_AIS_FRMD) begin
      out_nxt = TX_FBIT ? TX_DATA_IN : 1'b1;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      ais_ff        <= 2'h0;
      ysel_ff       <= 2'h0;
      TX_DATA_OUT   <= 1'b0;
      TX_DATA_VALID <= 1'b0;
    end else begin
      ais_ff        <= nxt_ais;
      ysel_ff       <= nxt_ysel;
      TX_DATA_VALID <= TX_BIT_EN;
      if (TX_BIT_EN) begin
        TX_DATA_OUT <= out_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  ais_unframed_a: assert property (TX_BIT_EN && nxt_ais == T1AG_AIS_UNFR |=> TX_DATA_OUT)
    else $error("unframed ais not all ones");
  ais_framed_a: assert property (TX_BIT_EN && nxt_ais == T1AG_AIS_FRMD && TX_FBIT |=>
    TX_DATA_OUT == $past(TX_DATA_IN)) else $error("framed ais lost framing bit");
  red_gate_a: assert property (##1 RED_ALARM == $past(ctrl_ff[T1AG_LOF_EN] && RX_LOF))
    else $error("red alarm not gated by enable");
  loss_irq_a: assert property ($rose(RX_LOF) |=> RX_FRAME_LOSS_IRQ ##1 !RX_FRAME_LOSS_IRQ)
    else $error("frame loss interrupt missing");
  auto_yellow_a: assert property (RED_ALARM && nxt_ais == 2'h0 && nxt_ysel == T1AG_YL_OFF &&
    mode_ff == T1AG_SF && TX_BIT_EN && !TX_FBIT && TX_BIT_POS == T1AG_SECOND_MSB |=> !TX_DATA_OUT)
    else $error("red alarm did not send yellow");
  sf_bit2_a: assert property (nxt_ais == 2'h0 && mode_ff == T1AG_SF && nxt_ysel[0] && TX_BIT_EN &&
    !TX_FBIT && TX_BIT_POS == T1AG_SECOND_MSB |=> !TX_DATA_OUT) else $error("sf bit 2 not zero");
  sf_fr12_a: assert property (nxt_ais == 2'h0 && mode_ff == T1AG_SF && nxt_ysel == T1AG_YL_FR12 &&
    TX_BIT_EN && TX_FBIT && TX_FRAME_NUM == T1AG_FRAME_12 |=> TX_DATA_OUT) else $error("fr12 bit not one");
  esf_pattern_a: assert property (nxt_ais == 2'h0 && esf && yst_ff == T1AG_SEND && TX_BIT_EN &&
    TX_DL_BIT |=> TX_DATA_OUT == ($past(bcnt_ff) < T1AG_PAT_HALF)) else $error("esf pattern wrong");
  run_hold_a: assert property (esf && pcnt_ff != 8'h00 |-> yst_ff == T1AG_SEND)
    else $error("timed run ended early");
  long_pulse_a: assert property (esf && timed && yst_ff == T1AG_SEND |=> yst_ff == T1AG_SEND)
    else $error("alarm stopped while bit 0 high");
  restart_a: assert property (esf && b0_rise |=> pcnt_ff == T1AG_PAT_RUN && yst_ff == T1AG_SEND)
    else $error("pattern count not restarted");
  bit1_hold_a: assert property (esf && ctrl_ff[T1AG_YL_B1] |=> yst_ff == T1AG_SEND)
    else $error("bit 1 did not hold alarm");
  nmode_a: assert property (nxt_ais == 2'h0 && mode_ff == T1AG_NFM && nxt_ysel != 2'h0 && TX_BIT_EN &&
    !TX_FBIT && TX_BIT_POS == T1AG_SECOND_MSB |=> !TX_DATA_OUT) else $error("n mode bit not zero");
  dm_ybit_a: assert property (nxt_ais == 2'h0 && mode_ff == T1AG_DMF && nxt_ysel != 2'h0 && TX_BIT_EN &&
    !TX_FBIT && TX_SLOT == T1AG_DM_SLOT && TX_BIT_POS == T1AG_DM_YBIT |=> !TX_DATA_OUT)
    else $error("dm y-bit not zero");
  yl_off_a: assert property (nxt_ais == 2'h0 && nxt_ysel == 2'h0 && !RED_ALARM && !esf && TX_BIT_EN |=>
    TX_DATA_OUT == $past(TX_DATA_IN)) else $error("data altered with yellow off");
  frame_latch_a: assert property (!(TX_BIT_EN && TX_FRAME_START) |=> $stable(ais_ff) && $stable(ysel_ff))
    else $error("select changed mid-frame");

endmodule

//--- verilog/t1ag_pkg.sv
package t1ag_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses on the AHB-Lite port)
  // ---------------------------------------------------------------
  localparam logic [11:0] T1AG_CTRL_OFS   = 12'h108;
  localparam logic [11:0] T1AG_MODE_OFS   = 12'h10c;
  localparam logic [11:0] T1AG_STAT_OFS   = 12'h110;
  localparam logic [7:0]  T1AG_CTRL_RST   = 8'h00;
  localparam logic [1:0]  T1AG_MODE_RST   = 2'h0;
  // ---------------------------------------------------------------
  // alarm_generation_control fields
  // ---------------------------------------------------------------
  localparam int          T1AG_YL_B0      = 4;
  localparam int          T1AG_YL_B1      = 5;
  localparam int          T1AG_AIS_LO     = 2;
  localparam int          T1AG_LOF_EN     = 6;
  localparam logic [1:0]  T1AG_AIS_UNFR   = 2'h1;
  localparam logic [1:0]  T1AG_AIS_FRMD   = 2'h2;
  localparam logic [1:0]  T1AG_YL_OFF     = 2'h0;
  localparam logic [1:0]  T1AG_YL_FR12    = 2'h2;
  localparam logic [1:0]  T1AG_YL_BIT2    = 2'h1;
  // ---------------------------------------------------------------
  // framing formats and frame geometry
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    T1AG_SF  = 2'h0,
    T1AG_ESF = 2'h1,
    T1AG_NFM = 2'h2,
    T1AG_DMF = 2'h3
  } t1ag_fmt_e;
  localparam logic [4:0]  T1AG_FRAME_12   = 5'h0c;
  localparam logic [2:0]  T1AG_SECOND_MSB = 3'h1;
  localparam logic [4:0]  T1AG_DM_SLOT    = 5'h17;
  localparam logic [2:0]  T1AG_DM_YBIT    = 3'h5;
  localparam logic [3:0]  T1AG_PAT_LAST   = 4'hf;
  localparam logic [3:0]  T1AG_PAT_HALF   = 4'h8;
  localparam logic [7:0]  T1AG_PAT_RUN    = 8'hff;
endpackage

//--- sim/t1ag_far_end.sv
`timescale 1ns/1ps
// remote terminal: only listens to the line, counts every bit it is handed
module t1ag_far_end (
  input  wire logic clk,
  input  wire logic line_bit,
  input  wire logic line_valid,
  output int        bits_seen,
  output logic      last_bit
);
  initial bits_seen = 0;
  initial last_bit = 1'b0;
  always @(posedge clk) begin
    if (line_valid === 1'b1) begin
      bits_seen <= bits_seen + 1;
      last_bit <= line_bit;
    end
  end
endmodule

//--- sim/t1ag_top_tb.sv
`timescale 1ns/1ps
module t1ag_top_tb;
  import t1ag_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, bit_en, din, fbit, dl_b, fst, rx_lof;
  logic        dout, dvalid, red, irq, ev, far_last;
  logic [1:0]  htrans;
  logic [2:0]  hsize, bpos;
  logic [4:0]  fnum, slot;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic        expq[$];
  int          miscompares, check_count, sent, far_cnt, seed;
  assign hready = hreadyout;
  t1ag_top dut_u (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
    .TX_BIT_EN(bit_en), .TX_DATA_IN(din), .TX_FBIT(fbit), .TX_DL_BIT(dl_b), .TX_FRAME_START(fst),
    .TX_FRAME_NUM(fnum), .TX_SLOT(slot), .TX_BIT_POS(bpos), .RX_LOF(rx_lof), .TX_DATA_OUT(dout),
    .TX_DATA_VALID(dvalid), .RED_ALARM(red), .RX_FRAME_LOSS_IRQ(irq));
  t1ag_far_end far_u (.clk(clk), .line_bit(dout), .line_valid(dvalid), .bits_seen(far_cnt), .last_bit(far_last));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, v);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, v);
    chk(nm, e, v);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic snd(input logic d, f, l, input logic [4:0] n, s, input logic [2:0] p, input logic e);
    @(posedge clk);
    bit_en <= 1'b1;
    din <= d;
    fbit <= f;
    dl_b <= l;
    fst <= f;
    fnum <= n;
    slot <= s;
    bpos <= p;
    expq.push_back(e);
    sent++;
    @(posedge clk);
    bit_en <= 1'b0;
  endtask
  function automatic logic eb(logic [1:0] m, a, y, logic f, logic [4:0] n, s, logic [2:0] p, logic d);
    if (a == T1AG_AIS_UNFR) return 1'b1;
    if (a == T1AG_AIS_FRMD) return f ? d : 1'b1;
    if (y == T1AG_YL_OFF) return d;
    if (m == T1AG_SF && !f && p == 3'h1 && y != T1AG_YL_FR12) return 1'b0;
    if (m == T1AG_SF && f && n == 5'h0c && y == T1AG_YL_FR12) return 1'b1;
    if (m == T1AG_NFM && !f && p == 3'h1) return 1'b0;
    if (m == T1AG_DMF && !f && s == 5'h17 && p == 3'h5) return 1'b0;
    return d;
  endfunction
  task automatic frm(input logic [1:0] m, a, y, input logic [4:0] n);
    logic       d;
    logic [4:0] s;
    for (int i = 0; i < 193; i++) begin
      d = 1'($urandom);
      s = 5'((i - 1) / 8);
      snd(d, i == 0, 1'b0, n, s, 3'(i - 1), eb(m, a, y, i == 0, n, s, 3'(i - 1), d));
    end
  endtask
  // on: pattern of eight ones then eight zeros, else link bit passes
  task automatic dl(input int n, input logic on);
    logic d;
    for (int i = 0; i < n * 16; i++) begin
      d = 1'($urandom);
      snd(d, 1'b1, 1'b1, 5'h1, 5'h0, 3'h0, on ? (i % 16 < 8) : d);
    end
  endtask
  // ---------------------------------------------------------------
  // line monitor
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (dvalid === 1'b1) begin
      if (expq.size() == 0) begin
        chk("extra bit", 32'h0, 32'h1);
      end else begin
        ev = expq.pop_front();
        chk("line bit", ev, dout);
      end
    end
  end
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
  initial begin
    {hsel, hwrite, bit_en, din, fbit, dl_b, fst, rx_lof, htrans, bpos, fnum, slot, haddr, hwdata} = '0;
    hsize = 3'h2;
    rst = 1'b1;
    miscompares = 0;
    check_count = 0;
    sent = 0;
    seed = $urandom(32'h0a7b);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("ctrl reset", T1AG_CTRL_OFS, 32'h0);
    rdc("mode reset", T1AG_MODE_OFS, 32'h0);
    wr(T1AG_CTRL_OFS, 32'hffff_ffa5);
    rdc("ctrl rw", T1AG_CTRL_OFS, 32'ha5);
    wr(T1AG_MODE_OFS, 32'h7);
    rdc("mode rw", T1AG_MODE_OFS, 32'h3);
    rdc("unmapped", 12'h200, 32'h0);
    $display("test registers done");
    // clear the selects first so entering esf starts no alarm
    wr(T1AG_CTRL_OFS, 32'h0);
    wr(T1AG_MODE_OFS, 32'h1);
    dl(1, 1'b0);
    wr(T1AG_CTRL_OFS, 32'h10);
    wr(T1AG_CTRL_OFS, 32'h0);
    dl(100, 1'b1);
    wr(T1AG_CTRL_OFS, 32'h10);
    wr(T1AG_CTRL_OFS, 32'h0);
    dl(255, 1'b1);
    dl(1, 1'b0);
    wr(T1AG_CTRL_OFS, 32'h10);
    dl(256, 1'b1);
    wr(T1AG_CTRL_OFS, 32'h0);
    // the pattern under way when the select drops is sent whole
    dl(1, 1'b1);
    dl(1, 1'b0);
    wr(T1AG_CTRL_OFS, 32'h20);
    dl(3, 1'b1);
    wr(T1AG_CTRL_OFS, 32'h0);
    dl(1, 1'b1);
    dl(1, 1'b0);
    $display("test esf yellow done");
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 16; c++) begin
        wr(T1AG_MODE_OFS, 32'(k == 0 ? 0 : k + 1));
        wr(T1AG_CTRL_OFS, 32'(c << 2));
        frm(2'(k == 0 ? 0 : k + 1), 2'(c), 2'(c >> 2), (c % 4 == 0) ? 5'h0c : 5'h05);
      end
    end
    $display("test frame alarms done");
    wr(T1AG_MODE_OFS, 32'h0);
    wr(T1AG_CTRL_OFS, 32'h40);
    rx_lof <= 1'b1;
    @(posedge clk);
    #1;
    chk("red on", 32'h1, red);
    chk("irq pulse", 32'h1, irq);
    @(posedge clk);
    #1;
    chk("irq end", 32'h0, irq);
    ahb(1'b0, T1AG_STAT_OFS, 32'h0, v);
    chk("status", 32'h3, v[1:0]);
    frm(2'h0, 2'h0, 2'h1, 5'h05);
    @(posedge clk);
    rx_lof <= 1'b0;
    wr(T1AG_CTRL_OFS, 32'h0);
    rx_lof <= 1'b1;
    @(posedge clk);
    #1;
    chk("red off", 32'h0, red);
    chk("irq plain", 32'h1, irq);
    repeat (3) @(posedge clk);
    chk("far end", sent, far_cnt);
    $display("test red alarm done");
    close_out();
  end
endmodule
